// file: core/rcps_core.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "rcps_cfg.svh"

// Function
// - Setup mode halts counting; next commits, steps
// - Four comparator sets, first after defaults
// - Upper limit signed six digits, default max
// - Lower limit signed six digits, default zero
// - Offset signed six digits, default 100000
// - Upper line selector codes 0-4, default 0
// - Lower line selector same codes, default 1
// - Raw count after multiplication, before weighting
// - Ratio weighting on, else weight one
// - Ratio 0.000001 to 0.999999, zero raised
// - Ratio value item skipped when weighting off
// - Full scale 1 to 999999, zero raised
// - Calibration code forces zero, plus, minus
// - Channel selects single-ended or differential input
// - Single phase: single-ended B pin gives direction
// - Multiplier codes x1, x2, x4; default x4
// - Direction code sets phase lead count sense
// - Divider codes scale by decades
// - Decimal point never alters count
// - BCD output polarity selector
// - Serial rate 2400/4800/9600, default 9600
// - Backlight on, off, or five-second auto
// - Single phase forces multiplier to x1
// - Open direction input reads low, counts up
module rcps_core #(
	parameter int unsigned BL_CYCLES = `RCPS_BL_SECONDS * `RCPS_CLK_HZ
) (
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	input  wire rcps_pkg::rcps_bus_type   bus,
	input  wire rcps_pkg::rcps_pins_type  pins,
	output logic [31:0]                   rdata_q,
	output logic                          setup_q,
	output logic                          backlight_q,
	output rcps_pkg::rcps_param_type      act_q,
	output logic signed [20:0]            comp_upper_q,
	output logic signed [20:0]            comp_lower_q,
	output logic signed [20:0]            sub1_q,
	output logic signed [20:0]            sub2_q,
	output logic signed [39:0]            main_q
);

	// Clip a signed entry to the six-digit range
	function automatic logic signed [20:0] clamp6(
		input logic signed [20:0] v);
		if (v > `RCPS_LIM_MAX)
			return `RCPS_LIM_MAX;
		if (v < -`RCPS_LIM_MAX)
			return -`RCPS_LIM_MAX;
		return v;
	endfunction

	// Positive six-digit entry, zero raised to the least step
	function automatic logic [19:0] clamp_pos(
		input logic signed [20:0] v);
		if (v <= 21'sh000000)
			return `RCPS_POS_MIN;
		if (v > $signed({1'b0, `RCPS_POS_MAX}))
			return `RCPS_POS_MAX;
		return v[19:0];
	endfunction

	// Out-of-range code keeps the previous selection
	function automatic logic [2:0] pick(input logic [2:0] old_v,
		input logic [2:0] new_v, input logic [2:0] max_v);
		return (new_v > max_v) ? old_v : new_v;
	endfunction

	// Sub-display line content
	function automatic logic signed [20:0] sub_sel(
		input logic [2:0] code, input logic signed [20:0] cnt);
		case (code)
			`RCPS_SUB_UPPER: return comp_upper_q;
			`RCPS_SUB_LOWER: return comp_lower_q;
			`RCPS_SUB_RATIO: return $signed({1'b0, act_q.ratio});
			`RCPS_SUB_OFFSET: return act_q.offset;
			default: return cnt;
		endcase
	endfunction

	rcps_pkg::rcps_pins_type    s1_q, s2_q, s3_q, flt_q, prv_q, flt_d;
	rcps_pkg::rcps_item_type    item_q, item_d;
	rcps_pkg::rcps_param_type   sh_q, sh_d, act_d;
	logic signed [20:0] up_s_q [4];
	logic signed [20:0] lo_s_q [4];
	logic signed [20:0] up_a_q [4];
	logic signed [20:0] lo_a_q [4];
	logic signed [20:0] up_s_d [4];
	logic signed [20:0] lo_s_d [4];
	logic signed [20:0] up_a_d [4];
	logic signed [20:0] lo_a_d [4];
	logic signed [20:0] edit_q, edit_d, cu_d, cl_d, s1_d, s2_d;
	logic signed [39:0] raw_q, raw_d, main_d;
	logic signed [31:0] frac_q, frac_d, step, unit, sum;
	logic [31:0]        rdata_d;
	logic [26:0]        blc_q, blc_d;
	logic               setup_d, bl_d, clr_w, fact_w;
	logic               menu_ev, next_ev, any_ev;
	logic               a, b, pa, pb, a_rise, hit, up;

	// Input synchroniser; a level counts once stages two and three agree
	always_comb begin
		flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
		menu_ev = flt_q.key_menu & ~prv_q.key_menu;
		next_ev = flt_q.key_next & ~prv_q.key_next;
		any_ev = menu_ev | next_ev | (flt_q.key_other & ~prv_q.key_other);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			flt_q <= '0;
			prv_q <= '0;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
			prv_q <= flt_q;
		end
	end

	// Setup menu, edit copy and applied copy of all settings
	always_comb begin
		setup_d = setup_q;
		item_d = item_q;
		sh_d = sh_q;
		act_d = act_q;
		up_s_d = up_s_q;
		lo_s_d = lo_s_q;
		up_a_d = up_a_q;
		lo_a_d = lo_a_q;
		if (fact_w) begin
			sh_d = rcps_pkg::rcps_defaults();
			act_d = rcps_pkg::rcps_defaults();
			for (int i = 0; i < 4; i++) begin
				up_s_d[i] = `RCPS_DEF_UPPER;
				lo_s_d[i] = `RCPS_DEF_LOWER;
				up_a_d[i] = `RCPS_DEF_UPPER;
				lo_a_d[i] = `RCPS_DEF_LOWER;
			end
		end else if (menu_ev && !setup_q) begin
			setup_d = 1'b1;
			item_d = rcps_pkg::IT_COND;
			sh_d = act_q;
			up_s_d = up_a_q;
			lo_s_d = lo_a_q;
		end else if (menu_ev) begin
			setup_d = 1'b0;
			act_d = sh_q;
			up_a_d = up_s_q;
			lo_a_d = lo_s_q;
		end else if (next_ev && setup_q) begin
			item_d = rcps_pkg::rcps_item_type'(item_q + 5'h01);
			case (item_q)
				rcps_pkg::IT_COND: sh_d.cond = edit_q[1:0];
				rcps_pkg::IT_UPPER: up_s_d[sh_q.cond] = clamp6(edit_q);
				rcps_pkg::IT_LOWER: lo_s_d[sh_q.cond] = clamp6(edit_q);
				rcps_pkg::IT_OFFSET: sh_d.offset = clamp6(edit_q);
				rcps_pkg::IT_LINE1: sh_d.line1 =
					pick(sh_q.line1, edit_q[2:0], `RCPS_CODE_MAX4);
				rcps_pkg::IT_LINE2: sh_d.line2 =
					pick(sh_q.line2, edit_q[2:0], `RCPS_CODE_MAX4);
				rcps_pkg::IT_RATIO_EN: begin
					// value item only when weighting on
					sh_d.ratio_off = edit_q[0];
					item_d = edit_q[0] ? rcps_pkg::IT_FSCALE
						: rcps_pkg::IT_RATIO;
				end
				rcps_pkg::IT_RATIO: sh_d.ratio = clamp_pos(edit_q);
				rcps_pkg::IT_FSCALE: sh_d.fscale = clamp_pos(edit_q);
				rcps_pkg::IT_CAL: sh_d.cal = 2'(pick({1'b0, sh_q.cal},
					edit_q[2:0], `RCPS_CODE_MAX2));
				rcps_pkg::IT_CHAN: sh_d.chan = edit_q[0];
				rcps_pkg::IT_STYPE: sh_d.stype = edit_q[0];
				rcps_pkg::IT_MULT: sh_d.mult = 2'(pick({1'b0, sh_q.mult},
					edit_q[2:0], `RCPS_CODE_MAX2));
				rcps_pkg::IT_DIR: sh_d.dir = edit_q[0];
				rcps_pkg::IT_DIV: sh_d.div = edit_q[1:0];
				rcps_pkg::IT_DP: sh_d.dp = edit_q[1:0];
				rcps_pkg::IT_BCD: sh_d.bcd_pol = edit_q[0];
				rcps_pkg::IT_BAUD: sh_d.baud = 2'(pick({1'b0, sh_q.baud},
					edit_q[2:0], `RCPS_CODE_MAX2));
				rcps_pkg::IT_BLIGHT: begin
					sh_d.blight = 2'(pick({1'b0, sh_q.blight},
						edit_q[2:0], `RCPS_CODE_MAX2));
					item_d = rcps_pkg::IT_COND;
				end
				default: item_d = rcps_pkg::IT_COND;
			endcase
		end
		// active set drives the comparator limits
		cu_d = up_a_d[act_d.cond];
		cl_d = lo_a_d[act_d.cond];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			setup_q <= 1'b0;
			item_q <= rcps_pkg::IT_COND;
			sh_q <= rcps_pkg::rcps_defaults();
			act_q <= rcps_pkg::rcps_defaults();
			comp_upper_q <= `RCPS_DEF_UPPER;
			comp_lower_q <= `RCPS_DEF_LOWER;
			for (int i = 0; i < 4; i++) begin
				up_s_q[i] <= `RCPS_DEF_UPPER;
				lo_s_q[i] <= `RCPS_DEF_LOWER;
				up_a_q[i] <= `RCPS_DEF_UPPER;
				lo_a_q[i] <= `RCPS_DEF_LOWER;
			end
		end else begin
			setup_q <= setup_d;
			item_q <= item_d;
			sh_q <= sh_d;
			act_q <= act_d;
			comp_upper_q <= cu_d;
			comp_lower_q <= cl_d;
			up_s_q <= up_s_d;
			lo_s_q <= lo_s_d;
			up_a_q <= up_a_d;
			lo_a_q <= lo_a_d;
		end
	end

	// Edge decode, raw count, weighting and decade divider
	always_comb begin
		a = act_q.chan ? flt_q.phase_a_input_d : flt_q.phase_a_input_p;
		pa = act_q.chan ? prv_q.phase_a_input_d : prv_q.phase_a_input_p;
		b = act_q.chan ? flt_q.phase_b_or_updown_input_d
			: flt_q.phase_b_or_updown_input_p;
		pb = act_q.chan ? prv_q.phase_b_or_updown_input_d
			: prv_q.phase_b_or_updown_input_p;
		a_rise = a & ~pa;
		if (act_q.stype) begin
			// single phase counts one edge only
			hit = a_rise;
			up = ~flt_q.phase_b_or_updown_input_p ^ act_q.dir;
		end else begin
			case (act_q.mult)
				`RCPS_MULT_X1: hit = a_rise;
				`RCPS_MULT_X2: hit = a ^ pa;
				default: hit = (a ^ pa) | (b ^ pb);
			endcase
			up = ((a ^ pa) ? (a != b) : (a == b)) ^ act_q.dir;
		end
		step = act_q.ratio_off ? `RCPS_UNIT_DIV1
			: $signed({12'h000, act_q.ratio});
		case (act_q.div)
			2'h0: unit = `RCPS_UNIT_DIV1;
			2'h1: unit = `RCPS_UNIT_DIV2;
			2'h2: unit = `RCPS_UNIT_DIV3;
			default: unit = `RCPS_UNIT_DIV4;
		endcase
		raw_d = raw_q;
		frac_d = frac_q;
		main_d = main_q;
		sum = up ? frac_q + step : frac_q - step;
		if (clr_w) begin
			raw_d = '0;
			frac_d = '0;
			main_d = '0;
		end else if (hit && !setup_q) begin
			raw_d = up ? raw_q + 40'sh0000000001 : raw_q - 40'sh0000000001;
			frac_d = sum;
			if (sum >= unit) begin
				main_d = main_q + 40'sh0000000001;
				frac_d = sum - unit;
			end else if (sum <= -unit) begin
				main_d = main_q - 40'sh0000000001;
				frac_d = sum + unit;
			end
		end
		s1_d = sub_sel(act_q.line1, 21'(raw_q / `RCPS_MILLION));
		s2_d = sub_sel(act_q.line2, 21'(raw_q % `RCPS_MILLION));
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			raw_q <= '0;
			frac_q <= '0;
			main_q <= '0;
			sub1_q <= '0;
			sub2_q <= '0;
		end else begin
			raw_q <= raw_d;
			frac_q <= frac_d;
			main_q <= main_d;
			sub1_q <= s1_d;
			sub2_q <= s2_d;
		end
	end

	// Backlight timer restarts on every key press
	always_comb begin
		if (any_ev)
			blc_d = 27'(BL_CYCLES);
		else
			blc_d = (blc_q != 27'h0000000) ? blc_q - 27'h0000001 : blc_q;
		case (act_q.blight)
			`RCPS_BL_ON: bl_d = 1'b1;
			`RCPS_BL_OFF: bl_d = 1'b0;
			default: bl_d = blc_d != 27'h0000000;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			blc_q <= '0;
			backlight_q <= 1'b0;
		end else begin
			blc_q <= blc_d;
			backlight_q <= bl_d;
		end
	end

	// Register port; read data valid only the cycle after the strobe
	always_comb begin
		clr_w = bus.wr && bus.addr == `RCPS_A_CTRL
			&& bus.wdata[`RCPS_CTRL_CLR];
		fact_w = bus.wr && bus.addr == `RCPS_A_CTRL
			&& bus.wdata[`RCPS_CTRL_FACT];
		edit_d = (bus.wr && bus.addr == `RCPS_A_EDIT)
			? $signed(bus.wdata[20:0]) : edit_q;
		rdata_d = '0;
		if (bus.rd) begin
			case (bus.addr)
				`RCPS_A_EDIT: rdata_d = 32'(edit_q);
				`RCPS_A_STATUS: rdata_d = {26'h0000000, item_q, setup_q};
				`RCPS_A_RAW_HI: rdata_d = {24'h000000, raw_q[39:32]};
				`RCPS_A_RAW_LO: rdata_d = raw_q[31:0];
				`RCPS_A_MAIN: rdata_d = main_q[31:0];
				`RCPS_A_CODES: rdata_d = {7'h00, act_q.cond, act_q.line1,
					act_q.line2, act_q.ratio_off, act_q.cal, act_q.chan,
					act_q.stype, act_q.mult, act_q.dir, act_q.div,
					act_q.dp, act_q.bcd_pol, act_q.baud, act_q.blight};
				`RCPS_A_UPPER: rdata_d = 32'(comp_upper_q);
				`RCPS_A_LOWER: rdata_d = 32'(comp_lower_q);
				`RCPS_A_OFFSET: rdata_d = 32'(act_q.offset);
				`RCPS_A_RATIO: rdata_d = {12'h000, act_q.ratio};
				`RCPS_A_FSCALE: rdata_d = {12'h000, act_q.fscale};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			edit_q <= '0;
			rdata_q <= '0;
		end else begin
			edit_q <= edit_d;
			rdata_q <= rdata_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence leave_s;
		setup_q && menu_ev && !fact_w;
	endsequence
	// Leaving setup may switch the mode off, so that key is excluded
	sequence auto_key_s;
		any_ev && act_q.blight == `RCPS_BL_AUTO && !fact_w
			&& !(setup_q && menu_ev);
	endsequence

	setup_freeze_a: assert property (setup_q && !clr_w |=> $stable(raw_q))
		else $error("count moved in setup");
	leave_apply_a: assert property (leave_s |=> !setup_q
		&& act_q == $past(sh_q)) else $error("edits not applied");
	fact_set_a: assert property (fact_w |=> act_q.cond == 2'h0
		&& comp_upper_q == `RCPS_DEF_UPPER) else $error("bad default set");
	upper_clip_a: assert property (setup_q && next_ev && !fact_w
		&& !menu_ev && item_q == rcps_pkg::IT_UPPER
		&& edit_q < -`RCPS_LIM_MAX |=> up_s_q[$past(sh_q.cond)]
		== -`RCPS_LIM_MAX) else $error("upper limit not clipped");
	ratio_skip_a: assert property (setup_q && next_ev && !menu_ev
		&& !fact_w && item_q == rcps_pkg::IT_RATIO_EN && edit_q[0]
		|=> item_q == rcps_pkg::IT_FSCALE) else $error("ratio not skipped");
	ratio_zero_a: assert property (setup_q && next_ev && !menu_ev
		&& !fact_w && item_q == rcps_pkg::IT_RATIO && edit_q == '0
		|=> sh_q.ratio == `RCPS_POS_MIN) else $error("ratio zero kept");
	single_x1_a: assert property (!setup_q && act_q.stype && !a_rise
		&& !clr_w |=> $stable(raw_q)) else $error("single phase miscount");
	quad_up_a: assert property (!setup_q && !act_q.stype
		&& act_q.mult == `RCPS_DEF_MULT && !act_q.dir && a_rise && !b
		&& !clr_w |=> raw_q == $past(raw_q) + 40'sh0000000001)
		else $error("lead did not count up");
	auto_light_a: assert property (auto_key_s |=> backlight_q[*8])
		else $error("backlight not lit");
endmodule

// file: core/rcps_cfg.svh
`ifndef RCPS_CFG_SVH
`define RCPS_CFG_SVH

// Register byte addresses
`define RCPS_A_CTRL     8'h00
`define RCPS_A_EDIT     8'h04
`define RCPS_A_STATUS   8'h08
`define RCPS_A_RAW_HI   8'h0C
`define RCPS_A_RAW_LO   8'h10
`define RCPS_A_MAIN     8'h14
`define RCPS_A_CODES    8'h18
`define RCPS_A_UPPER    8'h1C
`define RCPS_A_LOWER    8'h20
`define RCPS_A_OFFSET   8'h24
`define RCPS_A_RATIO    8'h28
`define RCPS_A_FSCALE   8'h2C

// Control register bit positions
`define RCPS_CTRL_CLR   0
`define RCPS_CTRL_FACT  1

// Value limits
`define RCPS_LIM_MAX    21'sh0F423F
`define RCPS_POS_MIN    20'h00001
`define RCPS_POS_MAX    20'hF423F
`define RCPS_MILLION    40'sh00000F4240

// Weighting units per divider code
`define RCPS_UNIT_DIV1  32'sh000F4240
`define RCPS_UNIT_DIV2  32'sh00989680
`define RCPS_UNIT_DIV3  32'sh05F5E100
`define RCPS_UNIT_DIV4  32'sh3B9ACA00

// Factory defaults
`define RCPS_DEF_UPPER  21'sh0F423F
`define RCPS_DEF_LOWER  21'sh000000
`define RCPS_DEF_OFFSET 21'sh0186A0
`define RCPS_DEF_RATIO  20'h186A0
`define RCPS_DEF_FSCALE 20'hF423F
`define RCPS_DEF_COND   2'h0
`define RCPS_DEF_LINE1  3'h0
`define RCPS_DEF_LINE2  3'h1
`define RCPS_DEF_ROFF   1'h1
`define RCPS_DEF_MULT   2'h2
`define RCPS_DEF_BAUD   2'h2
`define RCPS_DEF_BLIGHT 2'h2

// Mode codes
`define RCPS_CODE_MAX2  3'h2
`define RCPS_CODE_MAX4  3'h4
`define RCPS_MULT_X1    2'h0
`define RCPS_MULT_X2    2'h1
`define RCPS_BL_ON      2'h0
`define RCPS_BL_OFF     2'h1
`define RCPS_BL_AUTO    2'h2
`define RCPS_SUB_UPPER  3'h0
`define RCPS_SUB_LOWER  3'h1
`define RCPS_SUB_RATIO  3'h2
`define RCPS_SUB_OFFSET 3'h3

// Timing
`define RCPS_CLK_HZ     25000000
`define RCPS_BL_SECONDS 5

`endif

// file: core/rcps_pkg.sv
package rcps_pkg;
`include "rcps_cfg.svh"

	typedef enum logic [4:0] {
		IT_COND, IT_UPPER, IT_LOWER, IT_OFFSET, IT_LINE1, IT_LINE2,
		IT_RATIO_EN, IT_RATIO, IT_FSCALE, IT_CAL, IT_CHAN, IT_STYPE,
		IT_MULT, IT_DIR, IT_DIV, IT_DP, IT_BCD, IT_BAUD, IT_BLIGHT
	} rcps_item_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rcps_bus_type;

	typedef struct packed {
		logic phase_a_input_p;
		logic phase_b_or_updown_input_p;
		logic phase_a_input_d;
		logic phase_b_or_updown_input_d;
		logic key_menu;
		logic key_next;
		logic key_other;
	} rcps_pins_type;

	typedef struct packed {
		logic [1:0]         cond;
		logic signed [20:0] offset;
		logic [2:0]         line1;
		logic [2:0]         line2;
		logic               ratio_off;
		logic [19:0]        ratio;
		logic [19:0]        fscale;
		logic [1:0]         cal;
		logic               chan;
		logic               stype;
		logic [1:0]         mult;
		logic               dir;
		logic [1:0]         div;
		logic [1:0]         dp;
		logic               bcd_pol;
		logic [1:0]         baud;
		logic [1:0]         blight;
	} rcps_param_type;

	// Factory settings of the scalar items
	function automatic rcps_param_type rcps_defaults();
		rcps_param_type p;
		p = '0;
		p.cond = `RCPS_DEF_COND;
		p.offset = `RCPS_DEF_OFFSET;
		p.line1 = `RCPS_DEF_LINE1;
		p.line2 = `RCPS_DEF_LINE2;
		p.ratio_off = `RCPS_DEF_ROFF;
		p.ratio = `RCPS_DEF_RATIO;
		p.fscale = `RCPS_DEF_FSCALE;
		p.mult = `RCPS_DEF_MULT;
		p.baud = `RCPS_DEF_BAUD;
		p.blight = `RCPS_DEF_BLIGHT;
		return p;
	endfunction
endpackage

// file: tb/rcps_enc_model.sv
`timescale 1ns/1ns

// Incremental sensor; lines keep their level at rest like a real encoder
module rcps_enc_model (
	input  wire logic mclk,
	output logic      a_p,
	output logic      b_p,
	output logic      a_d,
	output logic      b_d
);
	localparam int HOLD = 8;
	logic [1:0] st;

	// Start at rest; the direction pin is left open, which reads low
	// open pin low
	initial begin
		st = 2'h0;
		a_p = 1'b0;
		b_p = 1'b0;
		a_d = 1'b0;
		b_d = 1'b0;
	end

	// One line state, held long enough to pass the input filter
	task automatic put(input logic ch, input logic a, input logic b);
		@(posedge mclk);
		if (ch) begin
			a_d <= a;
			b_d <= b;
		end else begin
			a_p <= a;
			b_p <= b;
		end
		repeat (HOLD) @(posedge mclk);
	endtask

	// Quadrature cycles on the pulse pins; fwd means phase A leads
	// phase lead sense
	task automatic quad(input logic fwd, input int n);
		repeat (4 * n) begin
			st = fwd ? st + 2'h1 : st - 2'h1;
			put(1'b0, st[0] ^ st[1], st[1]);
		end
	endtask

	// Single-phase pulses; B of the chosen pair is left as it is
	// single phase pulses
	task automatic pulse(input logic ch, input int n);
		repeat (n) begin
			put(ch, 1'b1, ch ? b_d : b_p);
			put(ch, 1'b0, ch ? b_d : b_p);
		end
	endtask

	// Up/down level on the single-ended B pin
	task automatic ud(input logic v);
		@(posedge mclk);
		b_p <= v;
	endtask
endmodule

// file: tb/tb_reversible_counter_param_set.sv
`timescale 1ns/1ns
`include "rcps_cfg.svh"
`define CHK(g, e) chk(64'(g), 64'(e))

module tb_reversible_counter_param_set;
	logic                     mclk;
	logic                     nrst;
	rcps_pkg::rcps_bus_type   bus;
	rcps_pkg::rcps_pins_type  pins;
	logic [2:0]               keys;
	logic                     a_p;
	logic                     b_p;
	logic                     a_d;
	logic                     b_d;
	logic [31:0]              rdata_q;
	logic                     setup_q;
	logic                     backlight_q;
	rcps_pkg::rcps_param_type act_q;
	logic signed [20:0]       comp_upper_q;
	logic signed [20:0]       comp_lower_q;
	logic signed [20:0]       sub1_q;
	logic signed [20:0]       sub2_q;
	logic signed [39:0]       main_q;
	logic signed [20:0]       tbl [19];
	int                       n_fail;
	int                       num_checks;

	// Clock of 40 ns
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// Sensor lines and keys share one pin bundle
	assign pins = {a_p, b_p, a_d, b_d, keys};

	rcps_core #(
		.BL_CYCLES(20)
	) i_rcps_core (
		.mclk        (mclk),
		.nrst        (nrst),
		.bus         (bus),
		.pins        (pins),
		.rdata_q     (rdata_q),
		.setup_q     (setup_q),
		.backlight_q (backlight_q),
		.act_q       (act_q),
		.comp_upper_q(comp_upper_q),
		.comp_lower_q(comp_lower_q),
		.sub1_q      (sub1_q),
		.sub2_q      (sub2_q),
		.main_q      (main_q)
	);

	rcps_enc_model i_rcps_enc_model (
		.mclk(mclk),
		.a_p (a_p),
		.b_p (b_p),
		.a_d (a_d),
		.b_d (b_d)
	);

	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		@(negedge mclk);
		`CHK(rdata_q, e);
	endtask

	// Key held long enough for the filter, then released
	task automatic press(input logic [2:0] k);
		@(posedge mclk);
		keys <= k;
		repeat (8) @(posedge mclk);
		keys <= 3'h0;
		repeat (8) @(posedge mclk);
	endtask

	// Bounded wait on setup mode; running out ends the run
	task automatic wait_setup(input logic v);
		for (int i = 0; i < 40; i++) begin
			if (setup_q === v) begin
				return;
			end
			@(posedge mclk);
		end
		`CHK(setup_q, v);
		stop_test();
	endtask

	// Commit each table entry, bar the ratio value when weighting is off, and step with the advance key
	task automatic walk();
		for (int i = 0; i < 19; i++) begin
			if (i == 7 && tbl[6][0]) begin
				rchk(`RCPS_A_STATUS, 32'h00000011);
				continue;
			end
			wr_reg(`RCPS_A_EDIT, 32'(tbl[i]));
			press(3'h2);
		end
		press(3'h4);
		wait_setup(1'b0);
	endtask

	// Main sequence
	initial begin
		n_fail = 0;
		num_checks = 0;
		nrst = 1'b0;
		bus = '0;
		keys = 3'h0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		// Factory values after reset, one unmapped read
		rchk(`RCPS_A_CODES, 32'h0003080A);
		rchk(`RCPS_A_UPPER, 32'h000F423F);
		rchk(`RCPS_A_LOWER, 32'h00000000);
		rchk(`RCPS_A_OFFSET, 32'h000186A0);
		rchk(`RCPS_A_RATIO, 32'h000186A0);
		rchk(`RCPS_A_FSCALE, 32'h000F423F);
		rchk(8'h40, 32'h00000000);
		`CHK(sub1_q, 21'sh0F423F);
		`CHK(sub2_q, 21'sh000000);
		// Default x4 two-phase count, both directions
		i_rcps_enc_model.quad(1'b1, 1);
		rchk(`RCPS_A_RAW_LO, 32'h00000004);
		rchk(`RCPS_A_MAIN, 32'h00000004);
		i_rcps_enc_model.quad(1'b0, 2);
		rchk(`RCPS_A_RAW_LO, 32'hFFFFFFFC);
		rchk(`RCPS_A_RAW_HI, 32'h000000FF);
		i_rcps_enc_model.pulse(1'b1, 3);
		rchk(`RCPS_A_RAW_LO, 32'hFFFFFFFC);
		// First session: clipping, one refused code, ratio on
		wr_reg(`RCPS_A_CTRL, 32'h00000001);
		press(3'h4);
		wait_setup(1'b1);
		rchk(`RCPS_A_STATUS, 32'h00000001);
		i_rcps_enc_model.quad(1'b1, 1);
		rchk(`RCPS_A_RAW_LO, 32'h00000000);
		tbl = '{21'sd1, -21'sd1000000, -21'sd5, 21'sd7, 21'sd4, 21'sd5,
			21'sd0, 21'sd0, 21'sd0, 21'sd2, 21'sd0, 21'sd0, 21'sd0,
			21'sd1, 21'sd0, 21'sd3, 21'sd1, 21'sd0, 21'sd1};
		walk();
		`CHK(act_q.cond, 2'h1);
		`CHK(comp_upper_q, -21'sd999999);
		`CHK(comp_lower_q, -21'sd5);
		`CHK(act_q.offset, 21'sh000007);
		`CHK({act_q.line1, act_q.line2}, 6'h21);
		`CHK({act_q.ratio_off, act_q.ratio, act_q.fscale},
			41'h00000100001);
		`CHK({act_q.cal, act_q.mult, act_q.dir, act_q.dp, act_q.bcd_pol,
			act_q.baud, act_q.blight}, 12'h8F1);
		`CHK(backlight_q, 1'b0);
		// x1 reversed, weight of one millionth leaves main at zero
		i_rcps_enc_model.quad(1'b1, 2);
		rchk(`RCPS_A_RAW_LO, 32'hFFFFFFFE);
		rchk(`RCPS_A_MAIN, 32'h00000000);
		`CHK(sub2_q, -21'sd5);
		// Second session: single phase on differential pair, 1/10
		wr_reg(`RCPS_A_CTRL, 32'h00000001);
		press(3'h4);
		wait_setup(1'b1);
		tbl = '{21'sd0, 21'sd500, -21'sd500, 21'sd0, 21'sd4, 21'sd4,
			21'sd1, 21'sd0, 21'sd1000000, 21'sd1, 21'sd1, 21'sd1, 21'sd1,
			21'sd0, 21'sd1, 21'sd0, 21'sd0, 21'sd1, 21'sd2};
		walk();
		`CHK(act_q.fscale, 20'hF423F);
		`CHK(comp_upper_q, 21'sh0001F4);
		`CHK({act_q.cal, act_q.chan, act_q.stype, act_q.mult, act_q.div,
			act_q.baud}, 10'h1D5);
		i_rcps_enc_model.ud(1'b0);
		i_rcps_enc_model.pulse(1'b1, 10);
		rchk(`RCPS_A_RAW_LO, 32'h0000000A);
		rchk(`RCPS_A_MAIN, 32'h00000001);
		`CHK(main_q, 40'sh0000000001);
		`CHK(sub2_q, 21'sh00000A);
		`CHK(sub1_q, 21'sh000000);
		i_rcps_enc_model.pulse(1'b0, 3);
		rchk(`RCPS_A_RAW_LO, 32'h0000000A);
		i_rcps_enc_model.ud(1'b1);
		i_rcps_enc_model.pulse(1'b1, 10);
		rchk(`RCPS_A_RAW_LO, 32'h00000000);
		// Automatic backlight lit after a key, dark after timeout
		press(3'h1);
		`CHK(backlight_q, 1'b1);
		repeat (30) @(posedge mclk);
		`CHK(backlight_q, 1'b0);
		// Factory restore of all settings
		wr_reg(`RCPS_A_CTRL, 32'h00000002);
		rchk(`RCPS_A_CODES, 32'h0003080A);
		`CHK(comp_upper_q, 21'sh0F423F);
		stop_test();
	end
endmodule
